// ==== verilog/dirs_pkg.sv ====
// Package for the display two-wire register slave.
// Assumes a 10 MHz system clock and a bus clock of at most 400 kHz.
package dirs_pkg;
  localparam logic [5:0] DIRS_ADDR_HIGH = 6'h13;
  localparam int DIRS_ADDR_BITS = 8;
  localparam int DIRS_DATA_BITS = 8;
  localparam int DIRS_REG_COUNT = 256;
  localparam logic [7:0] DIRS_REG_RESET = 8'h00;
  localparam logic [7:0] DIRS_SLEEP_REG = 8'h00;
  localparam int DIRS_SLEEP_BIT = 0;
  localparam logic [3:0] DIRS_BIT_LAST = 4'h7;
  localparam logic [3:0] DIRS_BIT_ACK = 4'h8;
  localparam int DIRS_SYS_CLK_KHZ = 10000;
  localparam int DIRS_MAX_SCL_KHZ = 400;
  localparam int DIRS_MIN_SYS_PER_SCL = DIRS_SYS_CLK_KHZ / DIRS_MAX_SCL_KHZ;
  typedef enum logic [4:0] {
    DIRS_IDLE = 5'b0_0001,
    DIRS_ADDR = 5'b0_0010,
    DIRS_REGA = 5'b0_0100,
    DIRS_WDAT = 5'b0_1000,
    DIRS_RDAT = 5'b1_0000
  } dirs_state_t;
endpackage : dirs_pkg

// ==== verilog/dirs_reg_if.sv ====
// Register access bundle between the serial engine and the register store.
// Assumes both ends share the single system clock.
`timescale 1ns/1ps
`default_nettype none
interface dirs_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sleep;
  modport engine (output wr_en, output addr, output wdata, input rdata);
  modport store (input wr_en, input addr, input wdata, output rdata, output sleep);
endinterface : dirs_reg_if
`default_nettype wire

// ==== verilog/dirs_sync.sv ====
// Two-flop synchroniser for the pins from outside the clock domain.
// Assumes the pins change slowly next to the system clock.
`timescale 1ns/1ps
`default_nettype none
module dirs_sync
  import dirs_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  // The pull-up idle level is high, so reset to ones to avoid a false start.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= '1;
      stage2 <= '1;
    end
    else
    begin
      stage1 <= d_i;
      stage2 <= stage1;
    end
  end
  assign q_o = stage2;
endmodule : dirs_sync
`default_nettype wire

// ==== verilog/dirs_regs.sv ====
// Register store reached only through the serial engine.
// Assumes single-cycle write strobes on the system clock.
`timescale 1ns/1ps
`default_nettype none
module dirs_regs
  import dirs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_block_i,
  dirs_reg_if.store bus
);
  logic [7:0] mem [DIRS_REG_COUNT];
  logic [7:0] next_mem [DIRS_REG_COUNT];
  always_comb
  begin
    next_mem = mem;
    if (bus.wr_en && !wr_block_i) // [R11]
      next_mem[bus.addr] = bus.wdata; // [R14]
  end
  // Sleep only gates other logic, so contents survive it untouched.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < DIRS_REG_COUNT; i++)
        mem[i] <= DIRS_REG_RESET; // [R12]
    end
    else
    begin
      mem <= next_mem;
    end
  end
  assign bus.rdata = mem[bus.addr]; // [R14]
  assign bus.sleep = mem[DIRS_SLEEP_REG][DIRS_SLEEP_BIT]; // [R13]
endmodule : dirs_regs
`default_nettype wire

// ==== verilog/dirs_top.sv ====
// Display two-wire register slave: serial engine and top level.
// Assumes an external bus master at no more than 400 kHz and pull-ups on both lines.
// Notes on behaviour
// R1 - Write is address, register, data bytes
// R2 - Read is address, register, readdress, data
// R3 - Target only, never drives clock
// R4 - Answers 010011X, X from strap pin
// R5 - Write address byte 4C or 4E
// R6 - Read address byte 4D or 4F
// R7 - Register address increments after each data byte
// R8 - Host holds stop until burst done
// R9 - Runs from bus clock, no video clocks; here SYS_CLK_I runs the logic and samples the bus clock
// R10 - Host keeps bus clock at 400 kHz
// R11 - Writes ignored while reset pin low
// R12 - Power-up loads all register defaults
// R13 - Sleep keeps serial port and registers
// R14 - All registers read back last write
// R15 - Acknowledge address, register, written data bytes
`timescale 1ns/1ps
`default_nettype none
module dirs_top
  import dirs_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic ADDRESS_SELECT_PIN_I,
  input wire logic ACTIVE_LOW_RESET_PIN_N_I,
  output logic SLEEP_REQUEST_BIT_O
);
  logic [3:0] pins;
  logic scl;
  logic sda;
  logic address_select_bit;
  logic chip_reset_n;
  dirs_reg_if rif ();

  // The bus, strap and chip reset pins cross two flops; RST_N_I does not; the bus clock is sampled, not used. [R9]
  dirs_sync #(.WIDTH(4)) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .d_i({SCL_I, SDA_I, ADDRESS_SELECT_PIN_I, ACTIVE_LOW_RESET_PIN_N_I}),
    .q_o(pins)
  );
  assign scl = pins[3];
  assign sda = pins[2];
  assign address_select_bit = pins[1];
  assign chip_reset_n = pins[0];

  dirs_regs u_regs (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .wr_block_i(!chip_reset_n),
    .bus(rif)
  );

  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  // The device only watches for start and stop; it never makes them. [R3]
  assign start_seen = scl && scl_d && sda_d && !sda;
  assign stop_seen = scl && scl_d && !sda_d && sda;
  // Conditions are judged on synchronised copies, so a pulse under one system clock is missed by design.

  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    addr_match = (b[7:2] == DIRS_ADDR_HIGH) && (b[1] == sel);
  endfunction : addr_match

  dirs_state_t state;
  dirs_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] regaddr;
  logic [7:0] next_regaddr;
  logic ack_drive;
  logic next_ack_drive;
  logic read_nack;
  logic next_read_nack;
  logic sda_out;
  logic next_sda_out;
  logic sda_oe;
  logic next_sda_oe;
  logic wr_en;
  logic next_wr_en;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic sleep_out;

  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_regaddr = regaddr;
    next_ack_drive = ack_drive;
    next_read_nack = read_nack;
    next_sda_out = sda_out;
    next_sda_oe = sda_oe;
    next_wr_en = 1'b0;
    next_wdata = wdata;
    if (stop_seen)
    begin
      next_state = DIRS_IDLE;
      next_sda_oe = 1'b0;
      next_ack_drive = 1'b0;
    end
    else if (start_seen)
    begin
      // A repeated start keeps the register address for the read phase. [R2]
      next_state = DIRS_ADDR;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
      next_ack_drive = 1'b0;
    end
    else
    begin
      unique case (state)
        DIRS_IDLE:
        begin
          // Nothing happens until a start; the data line stays free.
          next_sda_oe = 1'b0;
        end
        DIRS_ADDR, DIRS_REGA, DIRS_WDAT:
        begin
          if (scl_rise && bitcnt <= DIRS_BIT_LAST)
          begin
            next_shreg = {shreg[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == DIRS_BIT_ACK && !ack_drive)
          begin
            // Byte complete: decide whether to acknowledge it. [R15]
            next_ack_drive = 1'b1;
            if (state == DIRS_ADDR)
            begin
              if (addr_match(shreg, address_select_bit)) // [R4] [R5] [R6]
              begin
                next_sda_oe = 1'b1;
                next_sda_out = 1'b0;
              end
              else
              begin
                next_state = DIRS_IDLE;
              end
            end
            else
            begin
              next_sda_oe = 1'b1;
              next_sda_out = 1'b0;
              if (state == DIRS_REGA)
              begin
                next_regaddr = shreg; // [R1]
              end
              else
              begin
                next_wr_en = 1'b1; // [R1]
                next_wdata = shreg;
              end
            end
          end
          else if (scl_fall && ack_drive)
          begin
            // Acknowledge clock is over: release the line and move on.
            next_ack_drive = 1'b0;
            next_sda_oe = 1'b0;
            next_bitcnt = 4'h0;
            if (state == DIRS_ADDR)
            begin
              if (shreg[0])
              begin
                next_state = DIRS_RDAT;
                next_sda_oe = !rif.rdata[7];
                next_sda_out = 1'b0;
                next_shreg = {rif.rdata[6:0], 1'b0};
                next_bitcnt = 4'h1;
              end
              else
              begin
                next_state = DIRS_REGA;
              end
            end
            else if (state == DIRS_REGA)
            begin
              next_state = DIRS_WDAT;
            end
            else
            begin
              next_regaddr = regaddr + 8'h01; // [R7]
            end
          end
        end
        DIRS_RDAT:
        begin
          if (scl_fall && bitcnt <= DIRS_BIT_LAST)
          begin
            // Open drain: drive low for a zero, release for a one.
            next_sda_oe = !shreg[7];
            next_sda_out = 1'b0;
            next_shreg = {shreg[6:0], 1'b0};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == DIRS_BIT_ACK)
          begin
            // The last bit has had its full clock; free the line for the host's answer. [R15]
            next_sda_oe = 1'b0;
            next_bitcnt = DIRS_BIT_ACK + 4'h1;
          end
          else if (scl_rise && bitcnt == DIRS_BIT_ACK + 4'h1)
          begin
            next_read_nack = sda;
          end
          else if (scl_fall && bitcnt == DIRS_BIT_ACK + 4'h1)
          begin
            next_regaddr = regaddr + 8'h01; // [R7]
            if (read_nack)
            begin
              // Host declined more data; wait for its stop or restart. [R8]
              next_state = DIRS_IDLE;
              next_sda_oe = 1'b0;
            end
            else
            begin
              next_state = DIRS_RDAT;
              next_sda_oe = !rif.rdata[7];
              next_sda_out = 1'b0;
              next_shreg = {rif.rdata[6:0], 1'b0};
              next_bitcnt = 4'h1;
            end
          end
        end
        default:
        begin
          next_state = DIRS_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // The read pointer follows the next address, except during a write strobe when it holds regaddr, so read data is ready.
  assign rif.addr = (wr_en) ? regaddr : next_regaddr;
  assign rif.wr_en = wr_en;
  assign rif.wdata = wdata;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state <= DIRS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      regaddr <= 8'h00;
      ack_drive <= 1'b0;
      read_nack <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_en <= 1'b0;
      wdata <= 8'h00;
      sleep_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      regaddr <= next_regaddr;
      ack_drive <= next_ack_drive;
      read_nack <= next_read_nack;
      sda_out <= next_sda_out;
      sda_oe <= next_sda_oe;
      wr_en <= next_wr_en;
      wdata <= next_wdata;
      sleep_out <= rif.sleep; // [R13]
    end
  end

  assign SDA_O = sda_out;
  assign SDA_OE_O = sda_oe;
  assign SLEEP_REQUEST_BIT_O = sleep_out;
endmodule : dirs_top
`default_nettype wire

// ==== verif/dirs_props.sv ====
// Checker for the two-wire register slave, watching only the top level pins.
// Assumes the bus clock stays at or under 400 kHz against the 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dirs_props (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic ADDRESS_SELECT_PIN_I,
  input wire logic ACTIVE_LOW_RESET_PIN_N_I,
  input wire logic SLEEP_REQUEST_BIT_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  a_drive_only_low: assert property (SDA_OE_O |-> !SDA_O) else $error("data line driven high");
  a_ack_after_fall: assert property ($rose(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("data drive began near a high clock");
  a_release_clk_low: assert property ($fell(SDA_OE_O) |-> !SCL_I) else $error("data released with clock high");
  a_drive_held: assert property ($rose(SDA_OE_O) |=> SDA_OE_O [*8]) else $error("data drive too short");
  a_stop_free: assert property (SCL_I && $rose(SDA_I) |=> !SDA_OE_O [*4]) else $error("device drove after a stop");
  a_sleep_clk_low: assert property ($changed(SLEEP_REQUEST_BIT_O) |-> !SCL_I) else $error("store mid bit");
  a_sleep_gated: assert property ($changed(SLEEP_REQUEST_BIT_O) |-> $past(ACTIVE_LOW_RESET_PIN_N_I, 3))
    else $error("write stored while reset pin low");
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N_I |-> !SDA_OE_O && !SLEEP_REQUEST_BIT_O)
    else $error("outputs not cleared in reset");
  c_sleep: cover property ($rose(SLEEP_REQUEST_BIT_O));
  c_ack: cover property ($rose(SDA_OE_O));
  c_stop: cover property (SCL_I && $rose(SDA_I));
endmodule : dirs_props
bind dirs_top dirs_props u_props (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .ADDRESS_SELECT_PIN_I(ADDRESS_SELECT_PIN_I),
  .ACTIVE_LOW_RESET_PIN_N_I(ACTIVE_LOW_RESET_PIN_N_I), .SLEEP_REQUEST_BIT_O(SLEEP_REQUEST_BIT_O));
`default_nettype wire

// ==== verif/dirs_host.sv ====
// Bus master model that drives the two-wire clock and its side of the data line.
// Assumes pull-ups on both lines; the resolved data level comes back on sda_i.
`timescale 1ns/1ps
`default_nettype none
module dirs_host #(
  parameter int QTR_NS = 640
)(
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Four quarters of 640 ns give about 391 kHz; sums of 640 ns from a falling edge never hit a rising one.
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Also serves as the repeated start of a read.
  task automatic start;
    sda_o = 1'b1;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS sda_o = 1'b0;
    #QTR_NS scl_o = 1'b0;
  endtask : start
  // Issued only once every byte of a burst is done.
  task automatic stop;
    sda_o = 1'b0;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS sda_o = 1'b1;
    #QTR_NS;
  endtask : stop
  task automatic bit_x(input logic b, output logic s);
    sda_o = b;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS s = sda_i;
    #QTR_NS scl_o = 1'b0;
    #QTR_NS;
  endtask : bit_x
  // Sends o most significant bit first, then gives ak in the ninth slot.
  task automatic xb(input logic [7:0] o, input logic ak, output logic [7:0] i, output logic got);
    logic s;
    for (int k = 7; k >= 0; k--)
      bit_x(o[k], i[k]);
    bit_x(ak, s);
    got = !s;
  endtask : xb
endmodule : dirs_host
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the two-wire register slave with a host model.
// Assumes the checker is bound to the top level from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dirs_pkg::*;
  logic clk;
  logic rst_n;
  logic scl;
  logic hsda;
  logic sda_o;
  logic sda_oe;
  logic sel;
  logic rpin;
  logic sleep;
  int bad_count;
  int checks_done;
  logic [31:0] lf = 32'hc87f;
  // The line is pulled up, so it reads low whenever either party pulls it.
  wire logic sda = hsda & ~sda_oe;
  `define CHK(n,e,g) begin checks_done++; if ((g)!==(e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h",n,e,g); end end
  dirs_top uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .ADDRESS_SELECT_PIN_I(sel), .ACTIVE_LOW_RESET_PIN_N_I(rpin), .SLEEP_REQUEST_BIT_O(sleep));
  dirs_host host (.scl_o(scl), .sda_o(hsda), .sda_i(sda));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [7:0] dev(input logic s, input logic rd);
    return 8'h4C | {6'h00, s, rd};
  endfunction : dev
  task automatic wr2(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1,
                     input logic ea);
    logic [7:0] q;
    logic k;
    host.start();
    host.xb(a, 1'b1, q, k);
    `CHK("address ack", ea, k)
    if (ea)
    begin
      host.xb(r, 1'b1, q, k);
      `CHK("register ack", 1'b1, k)
      host.xb(d0, 1'b1, q, k);
      `CHK("data ack", 1'b1, k)
      host.xb(d1, 1'b1, q, k);
      `CHK("burst ack", 1'b1, k)
    end
    host.stop();
  endtask : wr2
  task automatic rd2(input logic s, input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] q;
    logic k;
    host.start();
    host.xb(dev(s, 1'b0), 1'b1, q, k);
    host.xb(r, 1'b1, q, k);
    host.start();
    host.xb(dev(s, 1'b1), 1'b1, q, k);
    `CHK("read address ack", 1'b1, k)
    host.xb(8'hFF, 1'b0, q, k);
    `CHK("read data", e0, q)
    host.xb(8'hFF, 1'b1, q, k);
    `CHK("read burst", e1, q)
    host.stop();
  endtask : rd2
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial
  begin
    logic [7:0] r;
    logic [7:0] d0;
    logic [7:0] d1;
    rst_n = 1'b0;
    sel = 1'b0;
    rpin = 1'b1;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (5) @(negedge clk);
    rd2(1'b0, 8'h7F, 8'h00, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      @(negedge clk) sel = s[0];
      repeat (4) @(negedge clk);
      lf = nxt(lf);
      // The first pass starts at the top register so the burst wraps into the sleep register.
      r = (s == 0) ? 8'hFF : (lf[7:0] | 8'h10);
      d0 = lf[15:8];
      d1 = (s == 0) ? (lf[23:16] | 8'h01) : lf[23:16];
      wr2(dev(sel, 1'b0), r, d0, d1, 1'b1);
      rd2(sel, r, d0, d1);
      if (s == 0)
        `CHK("sleep output", 1'b1, sleep)
      wr2(dev(~sel, 1'b0), r, ~d0, ~d1, 1'b0);
      @(negedge clk) rpin = 1'b0;
      repeat (4) @(negedge clk);
      wr2(dev(sel, 1'b0), r, ~d0, ~d1, 1'b1);
      @(negedge clk) rpin = 1'b1;
      repeat (4) @(negedge clk);
      rd2(sel, r, d0, d1);
    end
    wr2(dev(sel, 1'b0), 8'h00, 8'h00, 8'h00, 1'b1);
    `CHK("sleep cleared", 1'b0, sleep)
    rd2(sel, r, d0, d1);
    final_report();
  end
endmodule : tb
`default_nettype wire
